// [core/code_map_map.vh]
`ifndef CODE_MAP_MAP_VH
`define CODE_MAP_MAP_VH

// ==========================================================================
// code memory layout
`define RESET_VECTOR 16'h0000
`define VEC_EXT_ZERO 16'h0003
`define VEC_TIMER_ZERO 16'h000b
`define VEC_EXT_ONE 16'h0013
`define VEC_TIMER_ONE 16'h001b
`define VEC_SERIAL 16'h0023
`define VEC_EXT_TWO 16'h0083
`define VEC_CONVERTER 16'h008b
`define VEC_TIMER_THREE 16'h00eb
`define SELFPROG_LOW 16'h00ec
`define SELFPROG_HIGH 16'h0fdf
`define PROTECTED_FILL 8'h00

// ==========================================================================
// register addresses
`define ADDR_STACK_POINTER 8'h81
`define ADDR_TABLE_PTR_LOW 8'h82
`define ADDR_TABLE_PTR_HIGH 8'h83
`define ADDR_TIMER_ZERO_LOW 8'h8a
`define ADDR_TIMER_ONE_LOW 8'h8b
`define ADDR_TIMER_ZERO_HIGH 8'h8c
`define ADDR_TIMER_ONE_HIGH 8'h8d
`define ADDR_SELFPROG_CMD 8'h94
`define ADDR_SELFPROG_ADDR_LOW 8'h95
`define ADDR_SELFPROG_ADDR_HIGH 8'h96
`define ADDR_SELFPROG_RAM_MAP 8'h97

// ==========================================================================
// reset values and stack steps
`define RST_STACK_POINTER 8'h07
`define RST_TABLE_PTR 8'h00
`define STACK_STEP_PUSH 8'h01
`define STACK_STEP_CALL 8'h02

// ==========================================================================
// select vector encoding, one-hot on the peripheral select output
`define SEL_TIMER_ZERO_LOW 0
`define SEL_TIMER_ONE_LOW 1
`define SEL_TIMER_ZERO_HIGH 2
`define SEL_TIMER_ONE_HIGH 3
`define SEL_SELFPROG_CMD 4
`define SEL_SELFPROG_ADDR_LOW 5
`define SEL_SELFPROG_ADDR_HIGH 6
`define SEL_SELFPROG_RAM_MAP 7

`endif

// [core/irq_vector_table.v]
`timescale 1ns/1ps
`include "code_map_map.vh"

// ==========================================================================
// interrupt vector lookup, pure combinational
module irq_vector_table (
    // source index 0..7
    input wire [2:0] i_source,
    // fixed vector address
    output reg [15:0] o_vector
);

    // source order: ext0, timer0, ext1, timer1, serial, ext2, converter, timer3
    always @* begin
        case (i_source)
            3'h0: o_vector = `VEC_EXT_ZERO;
            3'h1: o_vector = `VEC_TIMER_ZERO;
            3'h2: o_vector = `VEC_EXT_ONE;
            3'h3: o_vector = `VEC_TIMER_ONE;
            3'h4: o_vector = `VEC_SERIAL;
            3'h5: o_vector = `VEC_EXT_TWO;
            3'h6: o_vector = `VEC_CONVERTER;
            default: o_vector = `VEC_TIMER_THREE;
        endcase
    end

endmodule // irq_vector_table

// [core/code_memory_map.v]
`timescale 1ns/1ps
`include "code_map_map.vh"

// ==========================================================================
// code memory map, pointer registers and register address decode
module code_memory_map (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // reset sources other than i_rst, each a synchronous level
    input wire i_reset_pin,
    input wire i_watchdog_reset,
    input wire i_low_voltage_detect,
    // program counter control from the core
    input wire i_pc_load,
    input wire [15:0] i_pc_value,
    input wire i_pc_advance,
    input wire i_irq_take,
    input wire [2:0] i_irq_source,
    output wire [15:0] o_pc,
    // register access from the core
    input wire [7:0] i_reg_addr,
    input wire i_reg_write,
    input wire i_reg_read,
    input wire [7:0] i_reg_wdata,
    input wire i_bit_access,
    input wire [2:0] i_bit_index,
    output wire [7:0] o_reg_rdata,
    output wire o_reg_hit,
    output wire o_bit_addressable,
    output wire [7:0] o_periph_select,
    // stack adjust from the core
    input wire i_stack_push,
    input wire i_stack_pop,
    input wire i_stack_call,
    input wire i_stack_return,
    output wire [7:0] o_stack_pointer,
    // table read and dump path
    input wire i_table_read,
    input wire [7:0] i_code_rdata,
    input wire i_dump_read,
    input wire i_security_enable,
    output wire [15:0] o_code_addr,
    output wire [7:0] o_table_data,
    output wire [7:0] o_dump_data,
    // self-programming target check
    input wire [15:0] i_selfprog_target,
    output wire o_selfprog_allowed
);

    // decode helpers
    function is_bit_addressable;
        input [7:0] addr;
        begin
            is_bit_addressable = (addr[2:0] == 3'h0);
        end
    endfunction

    function is_own_reg;
        input [7:0] addr;
        begin
            is_own_reg = (addr == `ADDR_STACK_POINTER) || (addr == `ADDR_TABLE_PTR_LOW) ||
                (addr == `ADDR_TABLE_PTR_HIGH);
        end
    endfunction

    reg [15:0] pc;
    reg [7:0] stack_pointer;
    reg [7:0] table_pointer_low;
    reg [7:0] table_pointer_high;
    reg [7:0] reg_rdata;
    reg [7:0] table_data;
    reg [7:0] dump_data;
    reg [7:0] next_stack_pointer;
    reg [7:0] cur_val;
    reg [7:0] write_val;
    reg [7:0] periph_select;
    wire [15:0] irq_vector;
    wire any_reset;
    wire [15:0] table_read_pointer;
    wire write_stack;
    wire write_low;
    wire write_high;

    // ======================================================================
    // vector lookup
    irq_vector_table u_vectors (
        .i_source(i_irq_source),
        .o_vector(irq_vector)
    );

    // ======================================================================
    // program counter; every reset source restarts at the reset vector
    assign any_reset = i_reset_pin | i_watchdog_reset | i_low_voltage_detect;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc <= `RESET_VECTOR;
        end else if (any_reset) begin
            pc <= `RESET_VECTOR;
        end else if (i_irq_take) begin
            pc <= irq_vector;
        end else if (i_pc_load) begin
            pc <= i_pc_value;
        end else if (i_pc_advance) begin
            pc <= pc + 16'h0001;
        end
    end

    // ======================================================================
    // byte value after a register write; bit access changes one bit only
    always @* begin
        case (i_reg_addr)
            `ADDR_STACK_POINTER: cur_val = stack_pointer;
            `ADDR_TABLE_PTR_LOW: cur_val = table_pointer_low;
            `ADDR_TABLE_PTR_HIGH: cur_val = table_pointer_high;
            default: cur_val = 8'h00;
        endcase
        write_val = i_reg_wdata;
        if (i_bit_access && is_bit_addressable(i_reg_addr)) begin
            write_val = cur_val;
            write_val[i_bit_index] = i_reg_wdata[0];
        end
    end

    // none of the own registers sit on a bit-addressable slot, so a bit write there is dropped
    assign write_stack = i_reg_write && !i_bit_access && (i_reg_addr == `ADDR_STACK_POINTER);
    assign write_low = i_reg_write && !i_bit_access && (i_reg_addr == `ADDR_TABLE_PTR_LOW);
    assign write_high = i_reg_write && !i_bit_access && (i_reg_addr == `ADDR_TABLE_PTR_HIGH);

    // ======================================================================
    // stack pointer; a direct write wins over a stack step in the same cycle
    always @* begin
        next_stack_pointer = stack_pointer;
        if (write_stack) begin
            next_stack_pointer = write_val;
        end else if (i_stack_call) begin
            next_stack_pointer = stack_pointer + `STACK_STEP_CALL;
        end else if (i_irq_take) begin
            next_stack_pointer = stack_pointer + `STACK_STEP_CALL;
        end else if (i_stack_push) begin
            next_stack_pointer = stack_pointer + `STACK_STEP_PUSH;
        end else if (i_stack_return) begin
            next_stack_pointer = stack_pointer - `STACK_STEP_CALL;
        end else if (i_stack_pop) begin
            next_stack_pointer = stack_pointer - `STACK_STEP_PUSH;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stack_pointer <= `RST_STACK_POINTER;
        end else if (any_reset) begin
            stack_pointer <= `RST_STACK_POINTER;
        end else begin
            stack_pointer <= next_stack_pointer;
        end
    end

    // ======================================================================
    // table read pointer bytes
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            table_pointer_low <= `RST_TABLE_PTR;
            table_pointer_high <= `RST_TABLE_PTR;
        end else if (any_reset) begin
            table_pointer_low <= `RST_TABLE_PTR;
            table_pointer_high <= `RST_TABLE_PTR;
        end else begin
            if (write_low) begin
                table_pointer_low <= write_val;
            end
            if (write_high) begin
                table_pointer_high <= write_val;
            end
        end
    end

    // single pointer pair, no bank select
    assign table_read_pointer = {table_pointer_high, table_pointer_low};

    // code address: table read uses the pointer, otherwise the fetch address
    assign o_code_addr = i_table_read ? table_read_pointer : pc;

    // ======================================================================
    // peripheral register select, one-hot; the peripherals sit outside
    always @* begin
        periph_select = 8'h00;
        case (i_reg_addr)
            `ADDR_TIMER_ZERO_LOW: periph_select[`SEL_TIMER_ZERO_LOW] = 1'b1;
            `ADDR_TIMER_ONE_LOW: periph_select[`SEL_TIMER_ONE_LOW] = 1'b1;
            `ADDR_TIMER_ZERO_HIGH: periph_select[`SEL_TIMER_ZERO_HIGH] = 1'b1;
            `ADDR_TIMER_ONE_HIGH: periph_select[`SEL_TIMER_ONE_HIGH] = 1'b1;
            `ADDR_SELFPROG_CMD: periph_select[`SEL_SELFPROG_CMD] = 1'b1;
            `ADDR_SELFPROG_ADDR_LOW: periph_select[`SEL_SELFPROG_ADDR_LOW] = 1'b1;
            `ADDR_SELFPROG_ADDR_HIGH: periph_select[`SEL_SELFPROG_ADDR_HIGH] = 1'b1;
            `ADDR_SELFPROG_RAM_MAP: periph_select[`SEL_SELFPROG_RAM_MAP] = 1'b1;
            default: periph_select = 8'h00;
        endcase
    end

    assign o_periph_select = periph_select;
    assign o_reg_hit = is_own_reg(i_reg_addr);
    assign o_bit_addressable = is_bit_addressable(i_reg_addr);

    // ======================================================================
    // registered read data; bit reads return the chosen bit in bit 0
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_rdata <= 8'h00;
        end else if (i_reg_read) begin
            if (i_bit_access) begin
                reg_rdata <= {7'h00, cur_val[i_bit_index]};
            end else begin
                reg_rdata <= cur_val;
            end
        end
    end

    // ======================================================================
    // code data paths; protection masks only the dump path
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            table_data <= 8'h00;
            dump_data <= 8'h00;
        end else begin
            if (i_table_read) begin
                table_data <= i_code_rdata;
            end
            if (i_dump_read) begin
                dump_data <= i_security_enable ? `PROTECTED_FILL : i_code_rdata;
            end
        end
    end

    // ======================================================================
    // self-programming target window; the top area is refused outright
    assign o_selfprog_allowed = (i_selfprog_target >= `SELFPROG_LOW) &&
        (i_selfprog_target <= `SELFPROG_HIGH);

    assign o_pc = pc;
    assign o_stack_pointer = stack_pointer;
    assign o_reg_rdata = reg_rdata;
    assign o_table_data = table_data;
    assign o_dump_data = dump_data;

endmodule // code_memory_map

// [test/code_map_sva.sv]
`timescale 1ns/1ps
// ==========================================================================
// property checker for the code map block, bound to its ports
module code_map_sva (
    // clock and reset sources
    input wire i_clk, i_rst, i_reset_pin, i_watchdog_reset, i_low_voltage_detect,
    // program counter and stack
    input wire i_irq_take, i_stack_push, i_stack_call, i_reg_write,
    input wire [2:0] i_irq_source,
    input wire [15:0] o_pc,
    input wire [7:0] o_stack_pointer,
    // register decode
    input wire [7:0] i_reg_addr,
    input wire o_reg_hit, o_bit_addressable,
    input wire [7:0] o_periph_select,
    // code read paths
    input wire i_table_read, i_dump_read, i_security_enable, o_selfprog_allowed,
    input wire [7:0] i_code_rdata, o_table_data, o_dump_data,
    input wire [15:0] i_selfprog_target, o_code_addr
);
    // synchronous reset sources and a stack pointer write both override stepping
    wire any_rst = i_reset_pin | i_watchdog_reset | i_low_voltage_detect;
    wire sp_write = i_reg_write && (i_reg_addr == 8'h81);
    wire [7:0] want_sel = (i_reg_addr >= 8'h8a && i_reg_addr <= 8'h8d) ?
        8'h01 << (i_reg_addr - 8'h8a) : (i_reg_addr >= 8'h94 && i_reg_addr <= 8'h97) ?
        8'h10 << (i_reg_addr - 8'h94) : 8'h00;
    reg [15:0] want_vec;
    // first five slots are eight apart, the last three are irregular
    always @* begin
        case (i_irq_source)
            3'h5: want_vec = 16'h0083;
            3'h6: want_vec = 16'h008b;
            3'h7: want_vec = 16'h00eb;
            default: want_vec = {10'h000, i_irq_source, 3'h3};
        endcase
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_reset_load: assert property (any_rst |=> o_pc == 16'h0000 && o_stack_pointer == 8'h07)
        else $error("pc or stack pointer not reloaded");
    a_irq_vector: assert property (i_irq_take && !any_rst |=> o_pc == $past(want_vec))
        else $error("interrupt vector wrong");
    a_stack_two: assert property ((i_stack_call || i_irq_take) && !sp_write && !any_rst
        |=> o_stack_pointer == $past(o_stack_pointer) + 8'h02) else $error("call step wrong");
    a_stack_push: assert property (i_stack_push && !i_stack_call && !i_irq_take && !sp_write
        && !any_rst |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
        else $error("push step wrong");
    a_selfprog_window: assert property (o_selfprog_allowed ==
        (i_selfprog_target >= 16'h00ec && i_selfprog_target <= 16'h0fdf))
        else $error("self-program window wrong");
    a_dump_masked: assert property (i_dump_read && i_security_enable && !any_rst
        |=> o_dump_data == 8'h00) else $error("dump not masked");
    a_dump_true: assert property (i_dump_read && !i_security_enable && !any_rst
        |=> o_dump_data == $past(i_code_rdata)) else $error("dump data altered");
    a_table_true: assert property (i_table_read && !any_rst
        |=> o_table_data == $past(i_code_rdata)) else $error("table data altered");
    a_fetch_addr: assert property (!i_table_read |-> o_code_addr == o_pc)
        else $error("fetch address wrong");
    a_ptr_hit: assert property (o_reg_hit == (i_reg_addr >= 8'h81 && i_reg_addr <= 8'h83))
        else $error("pointer decode wrong");
    a_bit_decode: assert property (o_bit_addressable == (i_reg_addr[2:0] == 3'h0))
        else $error("bit decode wrong");
    a_periph_decode: assert property (o_periph_select == want_sel)
        else $error("peripheral select wrong");
endmodule // code_map_sva

// [test/code_store_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// code memory behind the block: bytes follow the address, so a wrong
// address gives a wrong byte rather than a lucky match
module code_store_model (
    // address from the block
    input wire [15:0] i_addr,
    // stored byte
    output wire [7:0] o_data
);
    // scrambled pattern keyed on both address bytes
    assign o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'ha5;
endmodule // code_store_model

// [test/code_memory_map_tb.sv]
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the code map block
module code_memory_map_tb;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] s;
        logic h;} row_t;
    logic i_clk = 1'b0, i_rst = 1'b1, i_reset_pin = 1'b0, i_watchdog_reset = 1'b0;
    logic i_low_voltage_detect = 1'b0, i_pc_load = 1'b0, i_pc_advance = 1'b0, i_irq_take = 1'b0;
    logic i_reg_write = 1'b0, i_reg_read = 1'b0, i_bit_access = 1'b0, i_stack_push = 1'b0;
    logic i_stack_pop = 1'b0, i_stack_call = 1'b0, i_stack_return = 1'b0, i_table_read = 1'b0;
    logic i_dump_read = 1'b0, i_security_enable = 1'b0;
    logic [2:0] i_irq_source = 3'h0, i_bit_index = 3'h0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
    logic [15:0] i_pc_value = 16'h0000, i_selfprog_target = 16'h0000;
    wire [15:0] o_pc, o_code_addr;
    wire [7:0] o_reg_rdata, o_periph_select, o_stack_pointer, o_table_data, o_dump_data;
    wire [7:0] i_code_rdata;
    wire o_reg_hit, o_bit_addressable, o_selfprog_allowed;
    int mismatches = 0, check_count = 0, cycles = 0;
    // address, write data, read back, select, hit
    row_t rows [8] = '{'{8'h81, 8'h5a, 8'h5a, 8'h00, 1'b1}, '{8'h82, 8'h34, 8'h34, 8'h00, 1'b1},
        '{8'h83, 8'h0f, 8'h0f, 8'h00, 1'b1}, '{8'h84, 8'h77, 8'h00, 8'h00, 1'b0},
        '{8'h8a, 8'h11, 8'h00, 8'h01, 1'b0}, '{8'h8d, 8'h22, 8'h00, 8'h08, 1'b0},
        '{8'h94, 8'h33, 8'h00, 8'h10, 1'b0}, '{8'h97, 8'h44, 8'h00, 8'h80, 1'b0}};
    logic [15:0] vectors [8] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h0083,
        16'h008b, 16'h00eb};
    logic [15:0] targets [5] = '{16'h00eb, 16'h00ec, 16'h0fdf, 16'h0fe0, 16'h0fff};

    code_memory_map uut (.*);
    code_store_model mem (.i_addr(o_code_addr), .o_data(i_code_rdata));

    // ======================================================================
    // clock, hang guard and shared tasks
    always #5 i_clk = ~i_clk;
    // about 63 cycles suffice, so a stall is cut short at cycle 500
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 500) begin
            mismatches++;
            conclude();
        end
    end
    task automatic tick(); @(posedge i_clk); #1; endtask
    task automatic pulse(ref logic s); s = 1'b1; tick(); s = 1'b0; endtask
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr = a; i_reg_wdata = d; i_reg_write = 1'b1; tick(); i_reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        i_reg_addr = a; i_reg_read = 1'b1; tick(); i_reg_read = 1'b0;
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (2) @(posedge i_clk);
        #1 i_rst = 1'b0;
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            check("hit", rows[k].h, o_reg_hit);
            check("select", rows[k].s, o_periph_select);
            rd(rows[k].a);
            check("rdata", rows[k].r, o_reg_rdata);
        end
        $display("register rows done");
        // pointer is now 0x0f34; dump is masked while the table path is not
        i_security_enable = 1'b1; i_table_read = 1'b1; i_dump_read = 1'b1;
        // let the combinational address settle before looking at it
        #1;
        check("code addr", 16'h0f34, o_code_addr);
        tick();
        i_table_read = 1'b0;
        check("table data", 8'h0f ^ 8'h34 ^ 8'ha5, o_table_data);
        check("dump data", 8'h00, o_dump_data);
        // with security off the dump shows the true byte at fetch address 0x0000
        i_security_enable = 1'b0;
        tick();
        i_dump_read = 1'b0;
        check("open dump", 8'h00 ^ 8'h00 ^ 8'ha5, o_dump_data);
        $display("code read test done");
        // each reset source in turn, from a disturbed state
        for (int k = 0; k < 3; k++) begin
            i_pc_value = 16'h1234; pulse(i_pc_load); pulse(i_pc_advance);
            check("pc", 16'h1235, o_pc);
            wr(8'h81, 8'h40); pulse(i_stack_push);
            check("stack", 8'h41, o_stack_pointer);
            wr(8'h83, 8'hff);
            {i_reset_pin, i_watchdog_reset, i_low_voltage_detect} = 3'b100 >> k;
            tick(); {i_reset_pin, i_watchdog_reset, i_low_voltage_detect} = 3'h0;
            check("reset pc", 16'h0000, o_pc);
            check("reset stack", 8'h07, o_stack_pointer);
            rd(8'h83);
            check("reset pointer", 8'h00, o_reg_rdata);
        end
        $display("reset source test done");
        // back to back interrupt entries, each taking two stack bytes
        // the take strobe is held up across entries rather than dropped and raised again
        i_irq_take = 1'b1;
        foreach (vectors[k]) begin
            i_irq_source = k[2:0];
            tick();
            check("vector", vectors[k], o_pc);
            check("irq stack", 8'h07 + 8'h02 * (k + 1), o_stack_pointer);
        end
        i_irq_take = 1'b0;
        $display("vector test done");
        // call, return and pop move the stack by two, two and one
        pulse(i_stack_call);
        check("call stack", 8'h19, o_stack_pointer);
        pulse(i_stack_return);
        check("return stack", 8'h17, o_stack_pointer);
        pulse(i_stack_pop);
        check("pop stack", 8'h16, o_stack_pointer);
        $display("stack step test done");
        foreach (targets[k]) begin
            i_selfprog_target = targets[k]; tick();
            check("selfprog", (k == 1 || k == 2), o_selfprog_allowed);
        end
        $display("self-program window test done");
        // a bit write to the stack pointer is refused
        i_bit_access = 1'b1; wr(8'h81, 8'hff);
        check("bit flag", 1'b0, o_bit_addressable);
        i_bit_access = 1'b0; rd(8'h81);
        check("bit write", 8'h16, o_reg_rdata);
        i_reg_addr = 8'h88; tick();
        check("bit flag", 1'b1, o_bit_addressable);
        $display("bit access test done");
        // asynchronous reset in mid-run restores every register
        wr(8'h82, 8'h5c);
        i_rst = 1'b1;
        tick();
        i_rst = 1'b0;
        check("rst pc", 16'h0000, o_pc);
        check("rst stack", 8'h07, o_stack_pointer);
        check("rst rdata", 8'h00, o_reg_rdata);
        rd(8'h82);
        check("rst low", 8'h00, o_reg_rdata);
        $display("mid-run reset test done");
        conclude();
    end
endmodule // code_memory_map_tb

bind code_memory_map code_map_sva chk (.*);
